// ---- inc/ctw_pkg.sv ----
// constants and decode functions for the charger timer and watchdog block
package ctw_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TICK_W = 17;
	localparam int TW = 22;

	localparam logic [7:0] ADDR_TIMER_IRQ_CONTROL = 8'h24;
	localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'h25;
	localparam logic [7:0] RST_TIMER_IRQ_CONTROL = 8'h00;
	localparam logic [7:0] RST_WATCHDOG_CONTROL = 8'h13;

	localparam int B_EOC_HI = 7;
	localparam int B_EOC_LO = 6;
	localparam int B_WAKE_HI = 5;
	localparam int B_WAKE_LO = 3;
	localparam int B_WAKE_EN = 2;
	localparam int B_REMIND = 1;
	localparam int B_RELEASE = 0;
	localparam int B_SUPERVISION_TIMER_ENABLE = 7;
	localparam int B_WDT_DLY = 4;
	localparam int B_WDT_HI = 1;
	localparam int B_WDT_LO = 0;

	localparam logic [TW-1:0] MS_PER_S = 22'h0003E8;
	localparam logic [TW-1:0] MS_PER_MIN = 22'h00EA60;
	localparam logic [TW-1:0] EOC_30_MIN = 22'h00001E;
	localparam logic [TW-1:0] EOC_45_MIN = 22'h00002D;
	localparam logic [TW-1:0] EOC_60_MIN = 22'h00003C;
	localparam logic [TW-1:0] WDT_RST_200_MS = 22'h0000C8;
	localparam logic [TW-1:0] WDT_RST_500_MS = 22'h0001F4;
	localparam logic [TW-1:0] REMIND_HOLD_MS = 22'h0003E8;
	localparam logic [TW-1:0] REMIND_RELEASE_MS = 22'h0003E8;
	localparam logic [TW-1:0] WAKE_2_MIN = 22'h000002;
	localparam logic [TW-1:0] WAKE_4_MIN = 22'h000004;
	localparam logic [TW-1:0] WAKE_8_MIN = 22'h000008;

	typedef enum logic [1:0] {WD_OFF, WD_RUN, WD_WAIT} ctw_wd_e;

	function automatic logic [TW-1:0] ctw_eoc_ms(input logic [1:0] code);
		logic [TW-1:0] m;
		case (code)
			2'h1: m = EOC_30_MIN;
			2'h2: m = EOC_45_MIN;
			2'h3: m = EOC_60_MIN;
			default: m = '0;
		endcase
		return TW'(m * MS_PER_MIN);
	endfunction

	// 4 s doubling to 64 s, then whole minutes, which break the doubling
	function automatic logic [TW-1:0] ctw_wake_ms(input logic [2:0] code);
		logic [TW-1:0] m;
		case (code)
			3'h5: m = TW'(WAKE_2_MIN * MS_PER_MIN);
			3'h6: m = TW'(WAKE_4_MIN * MS_PER_MIN);
			3'h7: m = TW'(WAKE_8_MIN * MS_PER_MIN);
			default: m = TW'((MS_PER_S << 2) << code);
		endcase
		return m;
	endfunction

	function automatic logic [TW-1:0] ctw_wdt_ms(input logic [1:0] code);
		return TW'(MS_PER_S << code);
	endfunction
endpackage

// ---- hdl/ctw_ms_timer.sv ----
// millisecond interval timer with clear and one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none
module ctw_ms_timer
	import ctw_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_tick,
	input wire logic i_run,
	input wire logic i_clear,
	input wire logic [TW-1:0] i_limit,
	output logic o_done
);
	logic [TW-1:0] cnt_reg;
	logic [TW-1:0] cnt_next;
	logic done_reg;
	logic done_next;

	always_comb begin
		cnt_next = cnt_reg;
		done_next = 1'b0;
		if (i_clear) begin
			cnt_next = '0;
		end else if (i_run && i_tick) begin
			if (TW'(cnt_reg + 1'b1) >= i_limit) begin
				cnt_next = '0;
				done_next = 1'b1;
			end else begin
				cnt_next = TW'(cnt_reg + 1'b1);
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			done_reg <= done_next;
		end
	end

	assign o_done = done_reg;
endmodule
`default_nettype wire

// ---- hdl/ctw_top.sv ----
// charger auxiliary timers, interrupt reminder and host watchdog
//
// Operation
// R01 - after end of charge, back-charging continues for 0, 30, 45 or 60 minutes by a 2-bit code.
// R02 - the wake-up interrupt interval is 4 s, 8 s, 16 s, 32 s, 64 s, 2, 4 or 8 min by code.
// R03 - the wake-up timer runs only while its enable bit is 1 and is held stopped at 0.
// R04 - with the reminder bit set, an unserviced interrupt is released for a while, then reasserted.
// R05 - writing 1 to the release control bit deasserts the pending interrupt; writing 0 does nothing.
// R06 - the watchdog enable starts the watchdog at 1 and disables and resets it at 0.
// R07 - the watchdog interrupt asserts 1, 2, 4 or 8 s after enabling, by a 2-bit code.
// R08 - after the watchdog interrupt, setup returns to defaults after 200 ms or 500 ms by one bit.
`timescale 1ns/1ps
`default_nettype none
module ctw_top
	import ctw_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	input wire logic i_eoc,
	input wire logic i_irq_req,
	output logic o_backcharge,
	output logic o_wake_event,
	output logic o_wdt_irq,
	output logic o_setup_reset,
	output logic o_irq_n
);
	logic [7:0] ctl12_reg, ctl12_next;
	logic [7:0] ctl13_reg, ctl13_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
	logic tick;
	logic bc_reg, bc_next;
	logic wake_flag_reg, wake_flag_next;
	logic wdt_flag_reg, wdt_flag_next;
	logic released_reg, released_next;
	logic req_prev_reg;
	logic phase_reg, phase_next;
	logic irq_n_reg, irq_n_next;
	logic setup_rst_reg, setup_rst_next;
	ctw_wd_e wd_reg, wd_next;
	logic bc_done, wake_done, wd_done, rm_done;
	logic wd_clear, rm_run, rm_clear;
	logic [TW-1:0] wd_limit, rm_limit;
	logic wr12, wr13, kick, irq_want, new_event;

	assign tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));
	assign wr12 = i_reg_wr && (i_reg_addr == ADDR_TIMER_IRQ_CONTROL);
	assign wr13 = i_reg_wr && (i_reg_addr == ADDR_WATCHDOG_CONTROL);
	// any register access counts as the host answering
	assign kick = i_reg_wr || i_reg_rd;
	assign new_event = wake_done || (wd_reg == WD_RUN && wd_done) || (i_irq_req && !req_prev_reg);
	assign irq_want = (i_irq_req || wake_flag_reg || wdt_flag_reg) && !released_reg;

	always_comb begin
		tick_cnt_next = tick ? '0 : TICK_W'(tick_cnt_reg + 1'b1);
		ctl12_next = ctl12_reg;
		ctl13_next = ctl13_reg;
		if (wr12) begin
			ctl12_next = i_reg_wdata;
			ctl12_next[B_RELEASE] = 1'b0;
		end
		if (wr13) begin
			ctl13_next = i_reg_wdata;
		end
		rdata_next = rdata_reg;
		if (i_reg_rd) begin
			case (i_reg_addr)
				ADDR_TIMER_IRQ_CONTROL: rdata_next = ctl12_reg;
				ADDR_WATCHDOG_CONTROL: rdata_next = ctl13_reg;
				default: rdata_next = 8'h00;
			endcase
		end
		bc_next = bc_reg;
		if (bc_done) begin
			bc_next = 1'b0;
		end
		if (i_eoc) begin
			bc_next = (ctl12_reg[B_EOC_HI:B_EOC_LO] != 2'h0); // R01
		end
		wd_next = wd_reg;
		setup_rst_next = 1'b0;
		wdt_flag_next = wdt_flag_reg;
		wake_flag_next = wake_flag_reg;
		released_next = released_reg;
		if (wr12 && i_reg_wdata[B_RELEASE]) begin
			wake_flag_next = 1'b0; // R05
			wdt_flag_next = 1'b0; // R05
			released_next = 1'b1; // R05
		end
		if (new_event) begin
			released_next = 1'b0;
		end
		if (wake_done) begin
			wake_flag_next = 1'b1;
		end
		case (wd_reg)
			WD_OFF: begin
				if (ctl13_reg[B_SUPERVISION_TIMER_ENABLE]) begin
					wd_next = WD_RUN; // R06
				end
			end
			WD_RUN: begin
				if (!ctl13_reg[B_SUPERVISION_TIMER_ENABLE]) begin
					wd_next = WD_OFF; // R06
				end else if (wd_done) begin
					wdt_flag_next = 1'b1; // R07
					wd_next = WD_WAIT;
				end
			end
			WD_WAIT: begin
				if (!ctl13_reg[B_SUPERVISION_TIMER_ENABLE]) begin
					wd_next = WD_OFF;
				end else if (wd_done) begin
					setup_rst_next = 1'b1; // R08
					ctl12_next = RST_TIMER_IRQ_CONTROL; // R08
					ctl13_next = RST_WATCHDOG_CONTROL; // R08
					wd_next = WD_OFF;
				end
			end
			default: wd_next = WD_OFF;
		endcase
		phase_next = phase_reg;
		if (!rm_run) begin
			phase_next = 1'b0;
		end else if (rm_done) begin
			phase_next = !phase_reg; // R04
		end
		irq_n_next = !(irq_want && !(ctl12_reg[B_REMIND] && phase_reg)); // R04
	end

	// timing restarts on a kick while in WD_RUN and on each state change
	assign wd_clear = (wd_reg != wd_next) || (wd_reg == WD_OFF) || (wd_reg == WD_RUN && kick); // R06
	assign wd_limit = (wd_reg == WD_WAIT) ?
		(ctl13_reg[B_WDT_DLY] ? WDT_RST_500_MS : WDT_RST_200_MS) : // R08
		ctw_wdt_ms(ctl13_reg[B_WDT_HI:B_WDT_LO]); // R07
	assign rm_run = ctl12_reg[B_REMIND] && irq_want; // R04
	assign rm_clear = !rm_run || rm_done;
	assign rm_limit = phase_reg ? REMIND_RELEASE_MS : REMIND_HOLD_MS;

	ctw_ms_timer u_bc (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_tick(tick),
		.i_run(bc_reg),
		.i_clear(!bc_reg || i_eoc),
		.i_limit(ctw_eoc_ms(ctl12_reg[B_EOC_HI:B_EOC_LO])), // R01
		.o_done(bc_done)
	);

	ctw_ms_timer u_wake (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_tick(tick),
		.i_run(ctl12_reg[B_WAKE_EN]), // R03
		.i_clear(!ctl12_reg[B_WAKE_EN]), // R03
		.i_limit(ctw_wake_ms(ctl12_reg[B_WAKE_HI:B_WAKE_LO])), // R02
		.o_done(wake_done)
	);

	ctw_ms_timer u_wd (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_tick(tick),
		.i_run(wd_reg != WD_OFF),
		.i_clear(wd_clear),
		.i_limit(wd_limit),
		.o_done(wd_done)
	);

	ctw_ms_timer u_rm (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_tick(tick),
		.i_run(rm_run),
		.i_clear(rm_clear && !rm_run),
		.i_limit(rm_limit),
		.o_done(rm_done)
	);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tick_cnt_reg <= '0;
			ctl12_reg <= RST_TIMER_IRQ_CONTROL;
			ctl13_reg <= RST_WATCHDOG_CONTROL;
			rdata_reg <= 8'h00;
			bc_reg <= 1'b0;
			wake_flag_reg <= 1'b0;
			wdt_flag_reg <= 1'b0;
			released_reg <= 1'b0;
			req_prev_reg <= 1'b0;
			phase_reg <= 1'b0;
			irq_n_reg <= 1'b1;
			setup_rst_reg <= 1'b0;
			wd_reg <= WD_OFF;
		end else begin
			tick_cnt_reg <= tick_cnt_next;
			ctl12_reg <= ctl12_next;
			ctl13_reg <= ctl13_next;
			rdata_reg <= rdata_next;
			bc_reg <= bc_next;
			wake_flag_reg <= wake_flag_next;
			wdt_flag_reg <= wdt_flag_next;
			released_reg <= released_next;
			req_prev_reg <= i_irq_req;
			phase_reg <= phase_next;
			irq_n_reg <= irq_n_next;
			setup_rst_reg <= setup_rst_next;
			wd_reg <= wd_next;
		end
	end

	assign o_reg_rdata = rdata_reg;
	assign o_backcharge = bc_reg;
	assign o_wake_event = wake_done;
	assign o_wdt_irq = wdt_flag_reg;
	assign o_setup_reset = setup_rst_reg;
	assign o_irq_n = irq_n_reg;
endmodule
`default_nettype wire

// ---- hdl/ctw_pad.sv ----
// no logic here; the block sits in ctw_top and ctw_ms_timer

// ---- verif/ctw_top_asserts.sv ----
// port assertions for the timer and watchdog block
`timescale 1ns/1ps
`default_nettype none
module ctw_top_asserts #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] o_reg_rdata,
	input wire logic i_eoc,
	input wire logic o_backcharge,
	input wire logic o_wake_event,
	input wire logic o_wdt_irq,
	input wire logic o_setup_reset,
	input wire logic o_irq_n
);
	int idle_reg, idle_next, hold_reg, hold_next;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// any access restarts the running watchdog, so idle time bounds it
	always_comb begin
		idle_next = (i_reg_wr || i_reg_rd) ? 0 : idle_reg + 1;
		hold_next = o_wdt_irq ? hold_reg + 1 : 0;
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			idle_reg <= 0;
			hold_reg <= 0;
		end else begin
			idle_reg <= idle_next;
			hold_reg <= hold_next;
		end
	end
	bc_start_a: assert property ($rose(o_backcharge) |-> $past(i_eoc))
		else $error("backcharge without eoc");
	wake_gap_a: assert property (o_wake_event |=> !o_wake_event [*8])
		else $error("wake repeats");
	wdt_early_a: assert property ($rose(o_wdt_irq) |-> idle_reg >= 990 * TICK_CYCLES)
		else $error("watchdog early");
	wdt_irq_a: assert property ($rose(o_wdt_irq) |=> !o_irq_n)
		else $error("watchdog irq missing");
	rel_clr_a: assert property ($fell(o_wdt_irq) |->
		$past(i_reg_wr && i_reg_addr == 8'h24 && i_reg_wdata[0])) else $error("flag lost");
	rel_read_a: assert property (i_reg_rd && i_reg_addr == 8'h24 |=> !o_reg_rdata[0])
		else $error("release bit reads 1");
	sr_delay_a: assert property (o_setup_reset && o_wdt_irq |->
		hold_reg inside {[198 * TICK_CYCLES:501 * TICK_CYCLES]}) else $error("reset delay");
	sr_regs_a: assert property (o_setup_reset ##1 i_reg_rd && !i_reg_wr &&
		i_reg_addr == 8'h25 |=> o_reg_rdata == 8'h13) else $error("setup not restored");
	cover property ($rose(o_backcharge));
	cover property (o_wake_event);
	cover property (o_setup_reset);
endmodule
bind ctw_top ctw_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.i_clk(i_clk),
	.i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
	.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_eoc(i_eoc),
	.o_backcharge(o_backcharge), .o_wake_event(o_wake_event), .o_wdt_irq(o_wdt_irq),
	.o_setup_reset(o_setup_reset), .o_irq_n(o_irq_n));
`default_nettype wire

// ---- verif/ctw_host.sv ----
// host model on the register strobe port
`timescale 1ns/1ps
`default_nettype none
module ctw_host (
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	initial begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// one strobe cycle; idle lines show junk, not the last value
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] dw,
		output logic [7:0] dr);
		@(posedge i_clk);
		#1;
		o_addr = a;
		o_wdata = dw;
		o_wr = w;
		o_rd = !w;
		@(posedge i_clk);
		#1;
		dr = i_rdata;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = ~a;
		o_wdata = ~dw;
	endtask
endmodule
`default_nettype wire

// ---- verif/tb_ctw_top.sv ----
// self-checking bench for the timer and watchdog block
`timescale 1ns/1ps
`default_nettype none
module tb_ctw_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic eoc = 1'b0;
	logic irq_req = 1'b0;
	logic [7:0] addr, wdata, rdata, d;
	logic reg_wr, reg_rd, bc, wake, wdt, sr, irq_n;
	int n_errors = 0;
	int checks_done = 0;
	int n;
	always #5 clk = ~clk;
	// ten cycles a millisecond keeps the run near 97k cycles
	ctw_top #(.TICK_CYCLES(10)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata),
		.i_eoc(eoc),
		.i_irq_req(irq_req), .o_backcharge(bc), .o_wake_event(wake), .o_wdt_irq(wdt),
		.o_setup_reset(sr), .o_irq_n(irq_n));
	ctw_host host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
		.o_wr(reg_wr), .o_rd(reg_rd));
	task automatic stop_test;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask
	task automatic wait_on(ref logic s, input int lim);
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= lim) begin
			n_errors++;
			stop_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		host.acc(1'b1, a, v, d);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		host.acc(1'b0, a, 8'h00, d);
		chk(d, e);
	endtask
	task automatic t_regs;
		rd_chk(8'h24, 8'h00);
		rd_chk(8'h25, 8'h13);
		wr(8'h24, 8'hFB);
		rd_chk(8'h24, 8'hFA);
		rd_chk(8'h3A, 8'h00);
		wr(8'h24, 8'h40);
		$display("regs done");
	endtask
	task automatic t_bc;
		eoc = 1'b1;
		@(posedge clk);
		#1;
		eoc = 1'b0;
		chk(bc, 1'b1);
		wr(8'h24, 8'h00);
		eoc = 1'b1;
		@(posedge clk);
		#1;
		eoc = 1'b0;
		chk(bc, 1'b0);
		$display("backcharge done");
	endtask
	task automatic t_wake;
		wr(8'h24, 8'h04);
		wait_on(wake, 40100);
		chk(n inside {[39980:40010]}, 1'b1);
		repeat (2) @(posedge clk);
		#1;
		chk(irq_n, 1'b0);
		wr(8'h24, 8'h01);
		@(posedge clk);
		#1;
		chk(irq_n, 1'b1);
		$display("wake done");
	endtask
	task automatic t_remind;
		wr(8'h24, 8'h02);
		irq_req = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk(irq_n, 1'b0);
		wait_on(irq_n, 10100);
		chk(n inside {[9800:10010]}, 1'b1);
		irq_req = 1'b0;
		wr(8'h24, 8'h00);
		$display("remind done");
	endtask
	task automatic t_wdt(input logic [7:0] cfg, input int t_wd, input int t_sr);
		wr(8'h25, cfg);
		wait_on(wdt, t_wd + 100);
		chk(n inside {[t_wd - 20:t_wd + 10]}, 1'b1);
		wait_on(sr, t_sr + 100);
		chk(n inside {[t_sr - 20:t_sr + 10]}, 1'b1);
		rd_chk(8'h25, 8'h13);
		wr(8'h24, 8'h01);
		chk(wdt, 1'b0);
		$display("watchdog done");
	endtask
	// shortest timeout, so a running watchdog would fire inside the wait
	task automatic t_wdt_off;
		wr(8'h25, 8'h00);
		repeat (10100) @(posedge clk);
		#1;
		chk(wdt, 1'b0);
		chk(irq_n, 1'b1);
		$display("watchdog off done");
	endtask
	initial begin
		repeat (12) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_regs();
		t_bc();
		t_wake();
		t_remind();
		t_wdt(8'h80, 10000, 2000);
		t_wdt(8'h91, 20000, 5000);
		t_wdt_off();
		stop_test();
	end
endmodule
`default_nettype wire
